/* File: lptq_cmp_model.sv */
// Purpose: behavioural comparators on the analogue side of the qualifier
// Assumes: levels in millivolts, two's complement
// Notes:   pattern inputs and pulse source switch at 0 mV
`timescale 1ns/1ps
module lptq_cmp_model
    import lptq_pkg::*;
(
    input  wire logic [15:0] ch1_mv,
    input  wire logic [15:0] ch2_mv,
    input  wire logic [15:0] src_mv,
    input  wire logic [15:0] thr_hi_mv,
    input  wire logic [15:0] thr_lo_mv,
    output lptq_cmp_t        cmp
);
    // Each output is high while its input lies above its threshold
    always_comb begin
        cmp.in1     = $signed(ch1_mv) > 0;
        cmp.in2     = $signed(ch2_mv) > 0;
        cmp.pulse   = $signed(src_mv) > 0;
        cmp.runt_lo = $signed(src_mv) > $signed(thr_lo_mv);
        cmp.runt_hi = $signed(src_mv) > $signed(thr_hi_mv);
    end
endmodule

/* File: lptq_pkg.sv */
// Purpose: shared constants and types of the trigger qualifier
// Assumes: 25 MHz sample clock, 32-bit register port
// Notes:   durations are held in steps of the duration grid
package lptq_pkg;
    localparam int unsigned  CLK_PERIOD_PS = 40000;
    localparam int unsigned  CLK_PERIOD_NS = CLK_PERIOD_PS / 1000;
    localparam int unsigned  STEP_PS       = 13200;
    localparam int unsigned  MIN_LIMIT_PS  = 39600;
    localparam longint       MAX_LIMIT_PS  = 64'd10_000_000_000_000;
    localparam int unsigned  TOL_PCT       = 5;
    localparam int unsigned  PCT_FULL      = 100;
    localparam int unsigned  AUTO_TO_NS    = 100_000_000;
    localparam int unsigned  CNT_W         = 32;
    localparam int unsigned  LIMIT_W       = 30;
    localparam logic [LIMIT_W-1:0] MIN_STEPS = LIMIT_W'(MIN_LIMIT_PS / STEP_PS);
    localparam logic [LIMIT_W-1:0] MAX_STEPS = LIMIT_W'((MAX_LIMIT_PS + STEP_PS / 2) / STEP_PS);
    // Register byte offsets
    localparam logic [7:0]   OFF_CTRL   = 8'h00;
    localparam logic [7:0]   OFF_LIMIT  = 8'h04;
    localparam logic [7:0]   OFF_THRESH = 8'h08;
    localparam logic [7:0]   OFF_PRESET = 8'h0c;
    localparam logic [7:0]   OFF_STATUS = 8'h10;
    localparam int unsigned  THR_LO_LSB = 16;
    localparam int unsigned  ST_PAT_BIT = 0;
    localparam int unsigned  ST_AUT_BIT = 1;
    localparam int unsigned  ST_CNT_LSB = 16;
    // Threshold presets in millivolts, two's complement
    localparam logic [15:0]  TTL_HI_MV  = 16'h07d0;
    localparam logic [15:0]  TTL_LO_MV  = 16'h0320;
    localparam logic [15:0]  ECL_HI_MV  = 16'hfbb4;
    localparam logic [15:0]  ECL_LO_MV  = 16'hfa24;
    localparam logic [15:0]  THR_RST_MV = 16'h0000;

    typedef enum logic [1:0] {TT_PATTERN, TT_STATE, TT_PULSE} lptq_type_t;
    typedef enum logic [2:0] {WH_TRUE_GOING, WH_FALSE_GOING, WH_SHORTER_THAN,
                              WH_LONGER_THAN, WH_EQUAL, WH_OUTSIDE_TOL} lptq_when_t;
    typedef enum logic [1:0] {FN_AND, FN_NAND, FN_NOR, FN_OR} lptq_func_t;
    typedef enum logic [1:0] {PC_WIDTH, PC_RUNT, PC_EDGE_SPEED} lptq_class_t;
    typedef enum logic [2:0] {PW_OCCURS, PW_SHORTER, PW_LONGER, PW_EQUAL,
                              PW_OUTSIDE} lptq_pwhen_t;
    typedef enum logic [1:0] {RP_EITHER, RP_POSITIVE, RP_NEGATIVE} lptq_pol_t;
    typedef enum logic [1:0] {PS_NONE, PS_TTL, PS_ECL} lptq_preset_t;

    typedef struct packed {
        logic        auto_mode;
        logic        slew_slower;
        lptq_pol_t   runt_pol;
        lptq_pwhen_t pulse_when;
        lptq_class_t pulse_class;
        logic [1:0]  input_sense;
        lptq_func_t  func;
        logic        clk_fall;
        logic        state_true;
        lptq_when_t  pat_when;
        lptq_type_t  trig_type;
    } lptq_ctrl_t;
    localparam int unsigned CTRL_W = $bits(lptq_ctrl_t);

    typedef struct packed {
        logic runt_hi;
        logic runt_lo;
        logic pulse;
        logic in2;
        logic in1;
    } lptq_cmp_t;
    localparam int unsigned NPIN = $bits(lptq_cmp_t);

    typedef struct packed {
        logic lt;
        logic gt;
        logic tol;
    } lptq_meas_t;

    // Compares a cycle count with a limit in grid steps, in picoseconds
    function automatic lptq_meas_t lptq_measure(input logic [CNT_W-1:0]   cnt,
                                                input logic [LIMIT_W-1:0] lim);
        logic [63:0] m;
        logic [63:0] l;
        logic [63:0] d;
        lptq_meas_t  r;
        m = 64'(cnt) * 64'(CLK_PERIOD_PS);
        l = 64'(lim) * 64'(STEP_PS);
        d = (m > l) ? (m - l) : (l - m);
        r.lt = (m < l);
        r.gt = (m > l);
        r.tol = ((d * 64'(PCT_FULL)) <= (l * 64'(TOL_PCT)));
        return r;
    endfunction
endpackage

/* File: lptq_top.sv */
// Purpose: pattern, state and pulse trigger qualification
// Assumes: comparator outputs arrive unsynchronised on pins
// Notes:   trig_o is a one-cycle pulse per accepted trigger
// Functional notes
// - true-going triggers on pattern becoming true
// - false-going triggers on pattern becoming false
// - shorter-than: true less than limit, then false
// - longer-than: true beyond limit triggers once
// - equal: true interval within five percent
// - outside tolerance: interval outside five percent band
// - limit held in grid steps, clamped
// - combine inputs with AND, NAND, NOR, OR
// - low-true inputs are inverted before combining
// - second input is clock, selectable edge
// - state true: trigger if state true at edge
// - state false: trigger if state false at edge
// - automatic mode self-triggers after timeout
// - normal mode never self-triggers
// - width class checks source pulse width
// - runt class checks runt criterion and width
// - edge speed class checks band crossing time
// - either polarity accepts both runt kinds
// - positive polarity ignores negative runts
// - negative polarity ignores positive runts
// - TTL preset loads both runt thresholds
// - ECL preset loads both runt thresholds
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lptq_top
    import lptq_pkg::*;
#(
    parameter int unsigned AUTO_TIMEOUT_CYC = AUTO_TO_NS / CLK_PERIOD_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        we,
    input  wire logic        re,
    output logic      [31:0] rdata,
    input  wire lptq_cmp_t   cmp_i,
    output logic             trig_o,
    output logic             trig_auto_o,
    output logic      [15:0] thr_hi_mv,
    output logic      [15:0] thr_lo_mv
);
    localparam int unsigned NCNT = 5;
    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(AUTO_TIMEOUT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic [NPIN-1:0]  s1_reg;
    logic [NPIN-1:0]  s2_reg;
    logic [NPIN-1:0]  s3_reg;
    logic [NPIN-1:0]  pin_reg;
    logic [NPIN-1:0]  pin_d_reg;
    lptq_cmp_t        pq;
    lptq_cmp_t        pd;
    lptq_ctrl_t       ctrl_reg;
    logic [LIMIT_W-1:0] limit_reg;
    logic [LIMIT_W-1:0] limit_next;
    logic [15:0]      thr_hi_reg;
    logic [15:0]      thr_lo_reg;
    logic [31:0]      rdata_reg;
    logic [CNT_W-1:0] cnt_reg [NCNT];
    logic [NCNT-1:0]  run;
    logic [CNT_W-1:0] to_cnt_reg;
    logic [15:0]      trig_cnt_reg;
    logic             trig_reg;
    logic             auto_reg;
    logic             fired_reg;
    logic             hi_seen_reg;
    logic             lo_seen_reg;
    logic             pat_now;
    logic             pat_prev;
    logic             pat_rise;
    logic             pat_fall;
    logic             pat_hit;
    logic             clk_edge;
    logic             state_val;
    logic             state_hit;
    logic             pos_evt;
    logic             neg_evt;
    logic             runt_hit;
    logic             width_hit;
    logic             slew_evt;
    logic             slew_hit;
    logic             qual_evt;
    logic             auto_evt;
    lptq_meas_t       m_pat;
    lptq_meas_t       m_pul;
    lptq_meas_t       m_pos;
    lptq_meas_t       m_neg;
    lptq_meas_t       m_slw;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                s1_reg[i]    <= 1'b0;
                s2_reg[i]    <= 1'b0;
                s3_reg[i]    <= 1'b0;
                pin_reg[i]   <= 1'b0;
                pin_d_reg[i] <= 1'b0;
            end else if (ce) begin
                s1_reg[i] <= cmp_i[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    pin_reg[i] <= s3_reg[i];
                end
                pin_d_reg[i] <= pin_reg[i];
            end
        end
    end
    assign pq = lptq_cmp_t'(pin_reg);
    assign pd = lptq_cmp_t'(pin_d_reg);

    // Pattern combine of the sense-corrected inputs
    function automatic logic pat_of(input lptq_cmp_t p, input lptq_ctrl_t c);
        logic a;
        logic b;
        a = p.in1 ^ c.input_sense[0];
        b = p.in2 ^ c.input_sense[1];
        case (c.func)
            FN_AND:  pat_of = a & b;
            FN_NAND: pat_of = ~(a & b);
            FN_NOR:  pat_of = ~(a | b);
            FN_OR:   pat_of = a | b;
            default: pat_of = 1'b0;
        endcase
    endfunction

    // Pulse-width style test shared by the width and runt classes
    function automatic logic pw_ok(input lptq_pwhen_t w, input lptq_meas_t m);
        case (w)
            PW_OCCURS:  pw_ok = 1'b1;
            PW_SHORTER: pw_ok = m.lt;
            PW_LONGER:  pw_ok = m.gt;
            PW_EQUAL:   pw_ok = m.tol;
            PW_OUTSIDE: pw_ok = ~m.tol;
            default:    pw_ok = 1'b0;
        endcase
    endfunction

    // Pattern edges
    assign pat_now  = pat_of(pq, ctrl_reg);
    assign pat_prev = pat_of(pd, ctrl_reg);
    assign pat_rise = pat_now & ~pat_prev;
    assign pat_fall = ~pat_now & pat_prev;

    // Interval counters: pattern, pulse, positive runt, negative runt, band
    assign run[0] = pat_now;
    assign run[1] = pq.pulse;
    assign run[2] = pq.runt_lo;
    assign run[3] = ~pq.runt_hi;
    assign run[4] = pq.runt_lo & ~pq.runt_hi;
    for (genvar k = 0; k < NCNT; k++) begin : g_cnt
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                cnt_reg[k] <= '0;
            end else if (ce) begin
                if (!run[k]) begin
                    cnt_reg[k] <= '0;
                end else if (cnt_reg[k] != CNT_MAX) begin
                    cnt_reg[k] <= cnt_reg[k] + 1'b1;
                end
            end
        end
    end

    // Count at interval end against the limit
    assign m_pat = lptq_measure(cnt_reg[0], limit_reg);
    assign m_pul = lptq_measure(cnt_reg[1], limit_reg);
    assign m_pos = lptq_measure(cnt_reg[2], limit_reg);
    assign m_neg = lptq_measure(cnt_reg[3], limit_reg);
    assign m_slw = lptq_measure(cnt_reg[4], limit_reg);

    // Pattern condition select
    always_comb begin
        case (ctrl_reg.pat_when)
            WH_TRUE_GOING:   pat_hit = pat_rise;
            WH_FALSE_GOING:  pat_hit = pat_fall;
            WH_SHORTER_THAN: pat_hit = pat_fall & m_pat.lt;
            WH_LONGER_THAN:  pat_hit = pat_now & m_pat.gt & ~fired_reg;
            WH_EQUAL:        pat_hit = pat_fall & m_pat.tol;
            WH_OUTSIDE_TOL:  pat_hit = pat_fall & ~m_pat.tol;
            default:         pat_hit = 1'b0;
        endcase
    end

    // Longer-than fires once per true interval
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fired_reg <= 1'b0;
        end else if (ce) begin
            fired_reg <= pat_now & (fired_reg | m_pat.gt);
        end
    end

    // State trigger: second input is the clock
    assign clk_edge  = ctrl_reg.clk_fall ? (pd.in2 & ~pq.in2) : (~pd.in2 & pq.in2);
    assign state_val = pd.in1 ^ ctrl_reg.input_sense[0];
    assign state_hit = clk_edge & (state_val == ctrl_reg.state_true);

    // Runt tracking: remember a crossing of the far threshold
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_seen_reg <= 1'b0;
            lo_seen_reg <= 1'b0;
        end else if (ce) begin
            if (pq.runt_hi) begin
                hi_seen_reg <= 1'b1;
            end else if (pq.runt_lo & ~pd.runt_lo) begin
                hi_seen_reg <= 1'b0;
            end
            if (~pq.runt_lo) begin
                lo_seen_reg <= 1'b1;
            end else if (~pq.runt_hi & pd.runt_hi) begin
                lo_seen_reg <= 1'b0;
            end
        end
    end
    assign pos_evt = pd.runt_lo & ~pq.runt_lo & ~hi_seen_reg;
    assign neg_evt = ~pd.runt_hi & pq.runt_hi & ~lo_seen_reg;

    // Runt polarity filter and optional width test
    always_comb begin
        case (ctrl_reg.runt_pol)
            RP_EITHER:   runt_hit = (pos_evt & pw_ok(ctrl_reg.pulse_when, m_pos)) |
                                    (neg_evt & pw_ok(ctrl_reg.pulse_when, m_neg));
            RP_POSITIVE: runt_hit = pos_evt & pw_ok(ctrl_reg.pulse_when, m_pos);
            RP_NEGATIVE: runt_hit = neg_evt & pw_ok(ctrl_reg.pulse_when, m_neg);
            default:     runt_hit = 1'b0;
        endcase
    end

    // Width and edge-speed tests
    assign width_hit = pd.pulse & ~pq.pulse & pw_ok(ctrl_reg.pulse_when, m_pul);
    assign slew_evt  = pd.runt_lo & ~pd.runt_hi & (pq.runt_hi | ~pq.runt_lo);
    assign slew_hit  = slew_evt & (ctrl_reg.slew_slower ? m_slw.gt : m_slw.lt);

    // Trigger type and pulse class select
    always_comb begin
        case (ctrl_reg.trig_type)
            TT_PATTERN: qual_evt = pat_hit;
            TT_STATE:   qual_evt = state_hit;
            TT_PULSE: begin
                case (ctrl_reg.pulse_class)
                    PC_WIDTH:      qual_evt = width_hit;
                    PC_RUNT:       qual_evt = runt_hit;
                    PC_EDGE_SPEED: qual_evt = slew_hit;
                    default:       qual_evt = 1'b0;
                endcase
            end
            default: qual_evt = 1'b0;
        endcase
    end

    // Self trigger only in automatic mode after a quiet timeout
    assign auto_evt = ctrl_reg.auto_mode & (to_cnt_reg == TO_LAST) & ~qual_evt;

    // Timeout counter restarts on every trigger
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            to_cnt_reg <= '0;
        end else if (ce) begin
            if (!ctrl_reg.auto_mode || qual_evt || auto_evt) begin
                to_cnt_reg <= '0;
            end else begin
                to_cnt_reg <= to_cnt_reg + 1'b1;
            end
        end
    end

    // Trigger output and count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            trig_reg     <= 1'b0;
            auto_reg     <= 1'b0;
            trig_cnt_reg <= '0;
        end else if (ce) begin
            trig_reg <= qual_evt | auto_evt;
            auto_reg <= auto_evt;
            if (qual_evt | auto_evt) begin
                trig_cnt_reg <= trig_cnt_reg + 1'b1;
            end
        end
    end

    // Limit write clamps into the documented range
    always_comb begin
        limit_next = wdata[LIMIT_W-1:0];
        if (wdata[31:LIMIT_W] != '0 || limit_next > MAX_STEPS) begin
            limit_next = MAX_STEPS;
        end else if (limit_next < MIN_STEPS) begin
            limit_next = MIN_STEPS;
        end
    end

    // Register writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg   <= lptq_ctrl_t'('0);
            limit_reg  <= MIN_STEPS;
            thr_hi_reg <= THR_RST_MV;
            thr_lo_reg <= THR_RST_MV;
        end else if (ce && we) begin
            case (addr)
                OFF_CTRL:  ctrl_reg <= lptq_ctrl_t'(wdata[CTRL_W-1:0]);
                OFF_LIMIT: limit_reg <= limit_next;
                OFF_THRESH: begin
                    thr_hi_reg <= wdata[THR_LO_LSB-1:0];
                    thr_lo_reg <= wdata[THR_LO_LSB+15:THR_LO_LSB];
                end
                OFF_PRESET: begin
                    if (wdata[1:0] == 2'(PS_TTL)) begin
                        thr_hi_reg <= TTL_HI_MV;
                        thr_lo_reg <= TTL_LO_MV;
                    end else if (wdata[1:0] == 2'(PS_ECL)) begin
                        thr_hi_reg <= ECL_HI_MV;
                        thr_lo_reg <= ECL_LO_MV;
                    end
                end
                default: ;
            endcase
        end
    end

    // Read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else if (ce) begin
            rdata_reg <= '0;
            if (re) begin
                case (addr)
                    OFF_CTRL:   rdata_reg <= 32'(ctrl_reg);
                    OFF_LIMIT:  rdata_reg <= 32'(limit_reg);
                    OFF_THRESH: rdata_reg <= {thr_lo_reg, thr_hi_reg};
                    OFF_STATUS: begin
                        rdata_reg[ST_PAT_BIT] <= pat_now;
                        rdata_reg[ST_AUT_BIT] <= auto_reg;
                        rdata_reg[ST_CNT_LSB+15:ST_CNT_LSB] <= trig_cnt_reg;
                    end
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end

    assign rdata       = rdata_reg;
    assign trig_o      = trig_reg;
    assign trig_auto_o = auto_reg;
    assign thr_hi_mv   = thr_hi_reg;
    assign thr_lo_mv   = thr_lo_reg;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_pat_sel(lptq_when_t w);
        ce && ctrl_reg.trig_type == TT_PATTERN && ctrl_reg.pat_when == w;
    endsequence
    sequence s_preset(logic [1:0] p);
        ce && we && addr == OFF_PRESET && wdata[1:0] == p;
    endsequence

    AST_TRUE_GOING: assert property (s_pat_sel(WH_TRUE_GOING) and pat_now && !pat_prev
        |=> trig_o) else $error("true-going edge missed");
    AST_FALSE_GOING: assert property (s_pat_sel(WH_FALSE_GOING) and !pat_now && pat_prev
        |=> trig_o) else $error("false-going edge missed");
    AST_SHORTER: assert property (s_pat_sel(WH_SHORTER_THAN) and pat_fall
        && !m_pat.lt && !ctrl_reg.auto_mode |=> !trig_o)
        else $error("shorter-than fired on long interval");
    AST_LONGER: assert property (s_pat_sel(WH_LONGER_THAN) and pat_now && m_pat.gt
        && !fired_reg |=> trig_o ##1 (!trig_o || !ce || ctrl_reg.auto_mode))
        else $error("longer-than not single");
    AST_EQUAL: assert property (s_pat_sel(WH_EQUAL) and pat_fall && m_pat.tol
        |=> trig_o) else $error("equal interval missed");
    AST_OUTSIDE: assert property (s_pat_sel(WH_OUTSIDE_TOL) and pat_fall && !m_pat.tol
        |=> trig_o) else $error("outside interval missed");
    AST_LIMIT_MIN: assert property (ce && we && addr == OFF_LIMIT && wdata < 32'(MIN_STEPS)
        |=> limit_reg == MIN_STEPS) else $error("limit not clamped");
    AST_STATE: assert property (ce && ctrl_reg.trig_type == TT_STATE && clk_edge
        && state_val == ctrl_reg.state_true |=> trig_o)
        else $error("state trigger missed");
    AST_AUTO: assert property (ce && ctrl_reg.auto_mode && to_cnt_reg == TO_LAST
        && !qual_evt |=> trig_o && trig_auto_o) else $error("auto trigger missed");
    AST_NORMAL: assert property (ce && !ctrl_reg.auto_mode && !qual_evt
        |=> !trig_o) else $error("self trigger in normal mode");
    AST_RUNT_POS: assert property (ctrl_reg.runt_pol == RP_POSITIVE && neg_evt && !pos_evt
        |-> !runt_hit) else $error("negative runt accepted");
    AST_RUNT_NEG: assert property (ctrl_reg.runt_pol == RP_NEGATIVE && pos_evt && !neg_evt
        |-> !runt_hit) else $error("positive runt accepted");
    AST_TTL: assert property (s_preset(2'(PS_TTL)) |=> thr_hi_mv == TTL_HI_MV
        && thr_lo_mv == TTL_LO_MV) else $error("TTL preset wrong");
    AST_ECL: assert property (s_preset(2'(PS_ECL)) |=> thr_hi_mv == ECL_HI_MV
        && thr_lo_mv == ECL_LO_MV) else $error("ECL preset wrong");
endmodule

/* File: lptq_top_bench.sv */
// Purpose: self-checking bench of the trigger qualifier
// Assumes: comparator model in front, short auto timeout
// Notes:   triggers are counted over a window after each stimulus
`timescale 1ns/1ps
module lptq_top_bench;
    import lptq_pkg::*;
    localparam logic [15:0] POS = 16'h0bb8;
    localparam logic [15:0] MID = 16'h0578;
    localparam logic [15:0] NEG = 16'hfc18;
    localparam logic [15:0] ZRO = 16'h0000;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        we      = 1'b0;
    logic        re      = 1'b0;
    logic        ce      = 1'b1;
    logic [31:0] rdata;
    logic        trig_o, trig_auto_o, bf, af;
    logic [15:0] thr_hi_mv, thr_lo_mv;
    logic [15:0] ch1 = NEG, ch2 = NEG, src = ZRO;
    lptq_cmp_t   cmp;
    lptq_ctrl_t  c;
    int          err_total = 0, check_count = 0, cyc = 0, t = 0, ta = 0, tp = 0, ntrig = 0;
    int          dur [3] = '{20, 33, 50};

    lptq_top #(.AUTO_TIMEOUT_CYC(20)) dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
        .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .cmp_i(cmp),
        .trig_o(trig_o), .trig_auto_o(trig_auto_o), .thr_hi_mv(thr_hi_mv),
        .thr_lo_mv(thr_lo_mv));
    lptq_cmp_model model (.ch1_mv(ch1), .ch2_mv(ch2), .src_mv(src),
        .thr_hi_mv(thr_hi_mv), .thr_lo_mv(thr_lo_mv), .cmp(cmp));

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    // Cuts a hang short and tallies every trigger pulse
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        ntrig <= ntrig + int'(trig_o === 1'b1);
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge ref_clk);
        we    <= 1'b0;
    endtask
    // Read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge ref_clk);
        re   <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    // Counts trigger pulses over n cycles
    task automatic run(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 t = t + int'(trig_o === 1'b1);
            ta = ta + int'(trig_auto_o === 1'b1);
        end
    endtask
    // Settle on base levels, hold peak levels n cycles, return, count
    task automatic ev(input logic [47:0] b, p, input int n, e);
        @(posedge ref_clk);
        {ch1, ch2, src} <= b;
        run(10);
        t = 0;
        {ch1, ch2, src} <= p;
        run(n);
        tp = t;
        {ch1, ch2, src} <= b;
        run(12);
        chk("trigger count", e, t);
    endtask
    function automatic logic pf(input logic [1:0] fn, input logic a, b);
        case (fn)
            2'h0: pf = a & b;
            2'h1: pf = ~(a & b);
            2'h2: pf = ~(a | b);
            default: pf = a | b;
        endcase
    endfunction

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        // Reset values, clamping, unmapped place, presets
        rd(OFF_CTRL, 32'h0000_0000);
        rd(OFF_LIMIT, 32'h0000_0003);
        rd(8'h14, 32'h0000_0000);
        wr(OFF_LIMIT, 32'h0000_0000);
        rd(OFF_LIMIT, 32'h0000_0003);
        wr(OFF_LIMIT, 32'hffff_ffff);
        rd(OFF_LIMIT, 32'h2d27_b04e);
        wr(OFF_PRESET, 32'h0000_0002);
        rd(OFF_THRESH, 32'hfa24_fbb4);
        wr(OFF_PRESET, 32'h0000_0001);
        rd(OFF_THRESH, 32'h0320_07d0);
        chk("threshold pins", 32'h0320_07d0, {thr_lo_mv, thr_hi_mv});
        // Edge conditions over every function and input sense
        wr(OFF_LIMIT, 32'h0000_0064);
        c = '0;
        for (int w = 0; w < 2; w++)
            for (int f = 0; f < 4; f++)
                for (int s = 0; s < 4; s++) begin
                    c.pat_when    = lptq_when_t'(w);
                    c.func        = lptq_func_t'(f);
                    c.input_sense = 2'(s);
                    wr(OFF_CTRL, 32'(c));
                    bf = pf(2'(f), s[0], s[1]);
                    af = pf(2'(f), ~s[0], ~s[1]);
                    ev({NEG, NEG, ZRO}, {POS, POS, ZRO}, 12, int'(bf ^ af));
                    chk("edge at peak", int'(w ? bf & ~af : ~bf & af), tp);
                end
        // State sampled at the chosen clock edge
        c = '0;
        c.trig_type = TT_STATE;
        for (int k = 0; k < 8; k++) begin
            c.state_true = k[0];
            c.clk_fall   = k[1];
            wr(OFF_CTRL, 32'(c));
            ev({k[2] ? POS : NEG, k[1] ? POS : NEG, ZRO},
               {k[2] ? POS : NEG, k[1] ? NEG : POS, ZRO}, 12, int'(k[2] == k[0]));
        end
        // Durations of 800, 1320 and 2000 ns against a 1320 ns limit
        for (int k = 0; k < 12; k++) begin
            c = '0;
            c.pat_when = lptq_when_t'(2 + k / 3);
            wr(OFF_CTRL, 32'(c));
            ev({NEG, NEG, ZRO}, {POS, POS, ZRO}, dur[k % 3], int'(12'haa1 >> k) & 1);
        end
        // Strobes are ignored while the clock enable is low
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(OFF_LIMIT, 32'h0000_0020);
        ce <= 1'b1;
        rd(OFF_LIMIT, 32'h0000_0064);
        // Width class, longer than the limit
        c = '0;
        c.trig_type  = TT_PULSE;
        c.pulse_when = PW_LONGER;
        wr(OFF_CTRL, 32'(c));
        for (int k = 0; k < 2; k++)
            ev({NEG, NEG, ZRO}, {NEG, NEG, POS}, k ? 50 : 20, k);
        // Runt polarity: positive runt, negative runt, full pulse
        c.pulse_class = PC_RUNT;
        c.pulse_when  = PW_OCCURS;
        for (int k = 0; k < 9; k++) begin
            c.runt_pol = lptq_pol_t'(k / 3);
            wr(OFF_CTRL, 32'(c));
            ev({NEG, NEG, k % 3 == 1 ? POS : ZRO}, {NEG, NEG, k % 3 == 2 ? POS : MID}, 8,
               int'(9'h08b >> k) & 1);
        end
        // Edge speed: 800 or 2000 ns in band, faster or slower test
        c.pulse_class = PC_EDGE_SPEED;
        for (int k = 0; k < 4; k++) begin
            c.slew_slower = k[1];
            wr(OFF_CTRL, 32'(c));
            ev({NEG, NEG, ZRO}, {NEG, NEG, MID}, k[0] ? 50 : 20, int'(k[0] == k[1]));
        end
        // Self triggers only in automatic mode, always flagged
        c = '0;
        c.auto_mode = 1'b1;
        wr(OFF_CTRL, 32'(c));
        t  = 0;
        ta = 0;
        run(25);
        chk("auto trigger seen", 32'h0000_0001, 32'(t != 0));
        chk("auto flag count", t, ta);
        c.auto_mode = 1'b0;
        wr(OFF_CTRL, 32'(c));
        t = 0;
        run(60);
        chk("normal mode idle", 32'h0000_0000, t);
        rd(OFF_STATUS, {ntrig[15:0], 16'h0000});
        end_of_test();
    end
endmodule
